// ==== verilog/hbd_host_bus_adapter.sv ====
// Host expansion bus decode and glue for a LAN controller adapter.
// Notes on behaviour
// [R01] Host I/O cycles are decoded only while address enable is low.
// [R02] Eight controller I/O bases, picked by three I/O base straps.
// [R03] Seven boot ROM bases, picked by three ROM straps; code seven disables.
// [R04] Boot ROM select goes low for memory reads inside the strapped window.
// [R05] Node ID ROM select goes low for I/O reads of its slot.
// [R06] First controller mode: data select low for data register accesses.
// [R07] First controller mode: link select low for link control registers.
// [R08] Second controller mode: the link select pin is one controller chip select.
// [R09] The four low host address bits are latched for the controller.
// [R10] Narrow mode: pull the shared pin low to shorten the I/O cycle.
// [R11] Wide mode: pull the shared pin low to report a 16-bit channel.
// [R12] Host channel reset drives the adapter reset output.
// [R13] Cycle shortening is timed from the host system clock.
// [R14] Controller type and bus width come from two mode straps.
// [R15] Host uses separate low strobes for I/O read, I/O write, memory read.
// [R16] Host writes to offsets 0x18 to 0x1F also pulse the adapter reset.
// [R17] Controller read and write strobes follow valid host reads and writes.
// [R18] Channel ready is released once the controller reports ready, or earlier if the host strobe ends.
// [R19] Host interrupt follows either controller interrupt input.
// [R20] Nothing is decoded while DMA acknowledge is low.
// [R21] Low address bits decode I/O, high address bits decode boot ROM.
`timescale 1ns/1ps
module hbd_host_bus_adapter #(
   parameter int COUNT_W = 16
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [5:0]  hostAddrHigh,
   input  wire logic [9:0]  hostAddrLow,
   input  wire logic        addrEnable,
   input  wire logic        dmaAckN,
   input  wire logic        ioReadN,
   input  wire logic        ioWriteN,
   input  wire logic        memReadN,
   input  wire logic        hostChannelReset,
   input  wire logic        hostSysClock,
   input  wire logic [2:0]  ioBaseStraps,
   input  wire logic [2:0]  bootRomBaseStraps,
   input  wire logic [1:0]  modeStraps,
   input  wire logic [1:0]  hostChannelReadyOutsIn,
   output logic      [1:0]  hostChannelReadyOutsOut,
   output logic      [1:0]  hostChannelReadyOutsOe,
   input  wire logic        cycleShortenOrWideNIn,
   output logic             cycleShortenOrWideNOut,
   output logic             cycleShortenOrWideNOe,
   output logic             hostIrq,
   input  wire logic        ctrlReadyN,
   input  wire logic        ctrlRxIrqN,
   input  wire logic        ctrlTxOrAnyIrqN,
   output logic      [3:0]  latchedLowAddr,
   output logic             dataRegsSelectN,
   output logic             linkRegsOrCtrlSelectN,
   output logic             bootRomSelectN,
   output logic             nodeIdRomSelectN,
   output logic             ctrlReadN,
   output logic             ctrlWriteN,
   output logic             adapterReset
);

   typedef struct packed {
      hbd_pkg::hbd_state_t state;
      logic [2:0]          settle;
      logic                strapsTaken;
      logic [2:0]          ioStrap;
      logic [2:0]          romStrap;
      logic [1:0]          mode;
      logic                decodeEn;
      logic                prevSysClk;
      logic [3:0]          lowAddr;
      logic                dataSelN;
      logic                linkSelN;
      logic                romSelN;
      logic                idSelN;
      logic                readN;
      logic                writeN;
      logic [1:0]          readyOut;
      logic [1:0]          readyOe;
      logic                cycleOut;
      logic                cycleOe;
      logic [7:0]          rstCnt;
      logic                resetOut;
      logic                irq;
      logic [COUNT_W-1:0]  accCount;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
   } hbd_top_state_t;

   hbd_top_state_t     q;
   hbd_top_state_t     next_q;
   hbd_pkg::hbd_pins_t pins;
   logic [4:0]         offset;
   logic [9:0]         ioBase;
   logic               ioCycle;
   logic               ioHit;
   logic               romHit;
   logic               ctrlHit;
   logic               idHit;
   logic               rstHit;
   logic               hostIdle;
   logic               sysClkRise;
   logic               wide;
   logic               apbDone;

   function automatic logic [9:0] ioBaseOf(input logic [2:0] code);
      ioBaseOf = hbd_pkg::IO_BASE_FIRST + hbd_pkg::IO_BASE_STEP * {7'h00, code};
   endfunction

   // ----------------------------------------------------------------
   // Every host and controller pin is asynchronous to the APB clock.
   // ----------------------------------------------------------------
   hbd_sync_if #(.W($bits(hbd_pkg::hbd_pins_t))) syncIf ();

   assign syncIf.raw = {addrEnable, dmaAckN, ioReadN, ioWriteN, memReadN, hostChannelReset, hostSysClock,
                        ctrlReadyN, ctrlRxIrqN, ctrlTxOrAnyIrqN, hostAddrHigh, hostAddrLow, ioBaseStraps,
                        bootRomBaseStraps, modeStraps};
   assign pins = syncIf.clean;

   hbd_input_sync #(.W($bits(hbd_pkg::hbd_pins_t))) inputSync (
      .clock  (clock),
      .resetn (resetn),
      .pins   (syncIf.filter)
   );

   // ----------------------------------------------------------------
   // Host cycle decode.
   // ----------------------------------------------------------------
   assign offset     = pins.sadrLo[4:0];
   assign ioBase     = ioBaseOf(q.ioStrap);
   assign wide       = q.mode[hbd_pkg::MODE_BIT_WIDE];
   assign hostIdle   = pins.iorN && pins.iowN && pins.smemrN;
   assign sysClkRise = pins.sysClk && !q.prevSysClk;
   assign ioCycle    = !pins.aen && pins.dmaAckN && (!pins.iorN || !pins.iowN); // R01 R15 R20
   assign ioHit      = ioCycle && q.strapsTaken && q.decodeEn
                       && pins.sadrLo[9:5] == ioBase[9:5]; // R02 R21
   assign romHit     = !pins.smemrN && pins.dmaAckN && q.strapsTaken && q.decodeEn
                       && q.romStrap != hbd_pkg::ROM_STRAP_OFF
                       && pins.sadrHi == hbd_pkg::ROM_BASE_FIRST + {3'h0, q.romStrap}; // R03 R21
   assign ctrlHit    = ioHit && offset < hbd_pkg::OFS_ID_ROM_LO;
   assign idHit      = ioHit && !pins.iorN && offset >= hbd_pkg::OFS_ID_ROM_LO
                       && offset < hbd_pkg::OFS_RESET_LO;
   assign rstHit     = ioHit && !pins.iowN && offset >= hbd_pkg::OFS_RESET_LO; // R16
   assign apbDone    = psel && penable && q.pready;

   always_comb begin
      next_q            = q;
      next_q.prevSysClk = pins.sysClk;
      next_q.irq        = !pins.rxIrqN || !pins.txIrqN; // R19

      // Straps are sampled once the synchronisers have filled after reset.
      if (!q.strapsTaken) begin
         next_q.settle = q.settle + 3'h1;
         if (q.settle == hbd_pkg::SYNC_SETTLE_CYCLES) begin
            next_q.strapsTaken = 1'b1;
            next_q.ioStrap     = pins.ioStraps;
            next_q.romStrap    = pins.romStraps;
            next_q.mode        = pins.mode; // R14
         end
      end

      // A host strobe that ends releases every select, strobe and pin enable, even mid-wait; a reset pulse runs on.
      if (q.state != hbd_pkg::ST_IDLE && hostIdle) begin
         next_q.state    = hbd_pkg::ST_IDLE;
         next_q.dataSelN = 1'b1;
         next_q.linkSelN = 1'b1;
         next_q.romSelN  = 1'b1;
         next_q.idSelN   = 1'b1;
         next_q.readN    = 1'b1;
         next_q.writeN   = 1'b1;
         next_q.readyOe  = 2'h0;
         next_q.cycleOe  = 1'b0;
      end else begin
         unique case (q.state)
            hbd_pkg::ST_IDLE: begin
               if (ctrlHit) begin
                  next_q.state   = hbd_pkg::ST_ACCESS;
                  next_q.lowAddr = pins.sadrLo[3:0]; // R09
                  if (q.mode[hbd_pkg::MODE_BIT_CTRL]) begin
                     next_q.linkSelN = 1'b0; // R08
                  end else if (offset < hbd_pkg::OFS_LINK_LO) begin
                     next_q.dataSelN = 1'b0; // R06
                  end else begin
                     next_q.linkSelN = 1'b0; // R07
                  end
                  next_q.readN    = pins.iorN; // R17
                  next_q.writeN   = pins.iowN; // R17
                  next_q.readyOe  = 2'h3; // R18
                  next_q.cycleOe  = wide; // R11
                  next_q.accCount = q.accCount + 1'b1;
               end else if (idHit) begin
                  next_q.state    = hbd_pkg::ST_HOLD;
                  next_q.lowAddr  = pins.sadrLo[3:0]; // R09
                  next_q.idSelN   = 1'b0; // R05
                  next_q.readN    = 1'b0; // R17
                  next_q.accCount = q.accCount + 1'b1;
               end else if (romHit) begin
                  next_q.state    = hbd_pkg::ST_HOLD;
                  next_q.romSelN  = 1'b0; // R04
                  next_q.readN    = 1'b0; // R17
                  next_q.accCount = q.accCount + 1'b1;
               end else if (rstHit) begin
                  next_q.state  = hbd_pkg::ST_HOLD;
                  next_q.rstCnt = hbd_pkg::RESET_PULSE_CYCLES; // R16
               end
            end
            hbd_pkg::ST_ACCESS: begin
               // Shortening must line up with a host clock edge.
               if (!wide && sysClkRise) begin
                  next_q.cycleOe = 1'b1; // R10 R13
               end
               if (!pins.ctrlReadyN) begin
                  next_q.readyOe = 2'h0; // R18
                  next_q.state   = hbd_pkg::ST_HOLD;
               end
            end
            hbd_pkg::ST_HOLD: begin
            end
         endcase
      end

      // ----------------------------------------------------------------
      // APB slave: one wait state, then the answer stands for one cycle.
      // ----------------------------------------------------------------
      next_q.pready  = 1'b0;
      next_q.pslverr = 1'b0;
      if (psel && penable && !q.pready) begin
         next_q.pready = 1'b1;
         next_q.prdata = 32'h0000_0000;
         unique case (paddr)
            hbd_pkg::REG_CTRL:   next_q.prdata = {31'h0000_0000, q.decodeEn};
            hbd_pkg::REG_STATUS: next_q.prdata = {17'h0_0000, q.state != hbd_pkg::ST_IDLE, cycleShortenOrWideNIn,
                                                  hostChannelReadyOutsIn, q.irq, q.resetOut, q.strapsTaken,
                                                  q.mode, q.romStrap, q.ioStrap};
            hbd_pkg::REG_COUNT:  next_q.prdata = 32'(q.accCount);
            default:             next_q.pslverr = 1'b1;
         endcase
      end
      if (apbDone && pwrite && !q.pslverr) begin
         if (paddr == hbd_pkg::REG_CTRL) begin
            next_q.decodeEn = pwdata[hbd_pkg::CTRL_DECODE_EN_BIT];
            if (pwdata[hbd_pkg::CTRL_SOFT_RESET_BIT]) begin
               next_q.rstCnt = hbd_pkg::RESET_PULSE_CYCLES;
            end
         end else if (paddr == hbd_pkg::REG_COUNT) begin
            next_q.accCount = '0;
         end
      end

      // The reset pulse counter runs down; the channel reset holds the reset output as a level.
      if (q.rstCnt != 8'h00 && next_q.rstCnt == q.rstCnt) begin
         next_q.rstCnt = q.rstCnt - 8'h01;
      end
      next_q.resetOut = pins.host_channel_reset || q.rstCnt != 8'h00; // R12 R16
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         q          <= '0;
         q.dataSelN <= 1'b1;
         q.linkSelN <= 1'b1;
         q.romSelN  <= 1'b1;
         q.idSelN   <= 1'b1;
         q.readN    <= 1'b1;
         q.writeN   <= 1'b1;
         q.decodeEn <= hbd_pkg::CTRL_DECODE_EN_RST;
         q.resetOut <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign prdata                  = q.prdata;
   assign pready                  = q.pready;
   assign pslverr                 = q.pslverr;
   assign hostChannelReadyOutsOut = q.readyOut;
   assign hostChannelReadyOutsOe  = q.readyOe;
   assign cycleShortenOrWideNOut  = q.cycleOut;
   assign cycleShortenOrWideNOe   = q.cycleOe;
   assign hostIrq                 = q.irq;
   assign latchedLowAddr          = q.lowAddr;
   assign dataRegsSelectN         = q.dataSelN;
   assign linkRegsOrCtrlSelectN   = q.linkSelN;
   assign bootRomSelectN          = q.romSelN;
   assign nodeIdRomSelectN        = q.idSelN;
   assign ctrlReadN               = q.readN;
   assign ctrlWriteN              = q.writeN;
   assign adapterReset            = q.resetOut;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   sequence seqResetHeld;
      q.resetOut [*8];
   endsequence

   sequence seqSelectStart;
      $fell(q.linkSelN) || $fell(q.dataSelN);
   endsequence

   a_aen_blocks_io: assert property (@(posedge clock) disable iff (!resetn) // R01
      (q.state == hbd_pkg::ST_IDLE && pins.aen) |=> q.linkSelN && q.dataSelN && q.idSelN)
      else $error("I/O select asserted while address enable was high");

   a_io_base_match: assert property (@(posedge clock) disable iff (!resetn) // R02
      seqSelectStart |-> $past(pins.sadrLo[9:5]) == ioBase[9:5])
      else $error("controller select for an address outside the strapped base");

   a_rom_window: assert property (@(posedge clock) disable iff (!resetn) // R04
      $fell(q.romSelN) |-> q.romStrap != hbd_pkg::ROM_STRAP_OFF
                           && $past(pins.sadrHi) == hbd_pkg::ROM_BASE_FIRST + {3'h0, q.romStrap})
      else $error("boot ROM select outside the strapped window");

   a_id_rom_slot: assert property (@(posedge clock) disable iff (!resetn) // R05
      $fell(q.idSelN) |-> $past(offset) >= hbd_pkg::OFS_ID_ROM_LO && $past(offset) < hbd_pkg::OFS_RESET_LO)
      else $error("ID ROM select outside its slot");

   a_single_cs_mode: assert property (@(posedge clock) disable iff (!resetn) // R08
      q.mode[hbd_pkg::MODE_BIT_CTRL] |-> q.dataSelN)
      else $error("data select used in the single chip select mode");

   a_low_addr_latch: assert property (@(posedge clock) disable iff (!resetn) // R09
      seqSelectStart |-> q.lowAddr == $past(pins.sadrLo[3:0]))
      else $error("latched low address does not match the host address");

   a_ready_after_ctrl: assert property (@(posedge clock) disable iff (!resetn) // R18
      ($fell(q.readyOe[0]) && $past(q.state) == hbd_pkg::ST_ACCESS && !$past(hostIdle)) |-> $past(!pins.ctrlReadyN))
      else $error("channel ready released before the controller was ready");

   a_reset_pulse: assert property (@(posedge clock) disable iff (!resetn) // R16
      (q.state == hbd_pkg::ST_IDLE && rstHit) |=> ##1 seqResetHeld)
      else $error("reset pulse from the reset range too short");

   a_host_channel_reset_follow: assert property (@(posedge clock) disable iff (!resetn) // R12
      pins.host_channel_reset |=> q.resetOut)
      else $error("channel reset not forwarded");

   a_irq_follow: assert property (@(posedge clock) disable iff (!resetn) // R19
      (!pins.rxIrqN || !pins.txIrqN) |=> q.irq)
      else $error("controller interrupt not forwarded");

   a_dma_blocks: assert property (@(posedge clock) disable iff (!resetn) // R20
      (q.state == hbd_pkg::ST_IDLE && !pins.dmaAckN) |=> q.state == hbd_pkg::ST_IDLE)
      else $error("host cycle decoded during DMA acknowledge");

   a_zws_on_sysclk: assert property (@(posedge clock) disable iff (!resetn) // R10 R13
      ($rose(q.cycleOe) && !wide) |-> $past(sysClkRise))
      else $error("cycle shortening not aligned to a host clock edge");

endmodule

// ==== common/hbd_pkg.sv ====
// Shared constants and types for the host bus adapter decode block.
package hbd_pkg;

   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_NS           = 50;
   localparam int unsigned RESET_PULSE_NS     = 1000;
   localparam int unsigned RESET_PULSE_CALC   = (RESET_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam logic [7:0]  RESET_PULSE_CYCLES = (RESET_PULSE_CALC < 1) ? 8'h01 : 8'(RESET_PULSE_CALC);
   localparam logic [2:0]  SYNC_SETTLE_CYCLES = 3'h4;

   // ----------------------------------------------------------------
   // Host address map.
   // ----------------------------------------------------------------
   localparam logic [9:0]  IO_BASE_FIRST   = 10'h200;
   localparam logic [9:0]  IO_BASE_STEP    = 10'h020;
   localparam logic [5:0]  ROM_BASE_FIRST  = 6'h30;
   localparam logic [2:0]  ROM_STRAP_OFF   = 3'h7;
   localparam logic [4:0]  OFS_LINK_LO     = 5'h08;
   localparam logic [4:0]  OFS_ID_ROM_LO   = 5'h10;
   localparam logic [4:0]  OFS_RESET_LO    = 5'h18;
   localparam int unsigned MODE_BIT_CTRL   = 0;
   localparam int unsigned MODE_BIT_WIDE   = 1;

   // ----------------------------------------------------------------
   // APB register map.
   // ----------------------------------------------------------------
   localparam int unsigned APB_ADDR_W          = 12;
   localparam logic [11:0] REG_CTRL            = 12'h000;
   localparam logic [11:0] REG_STATUS          = 12'h004;
   localparam logic [11:0] REG_COUNT           = 12'h008;
   localparam int unsigned CTRL_DECODE_EN_BIT  = 0;
   localparam int unsigned CTRL_SOFT_RESET_BIT = 1;
   localparam logic        CTRL_DECODE_EN_RST  = 1'b1;

   // ----------------------------------------------------------------
   // Types.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       aen;
      logic       dmaAckN;
      logic       iorN;
      logic       iowN;
      logic       smemrN;
      logic       host_channel_reset;
      logic       sysClk;
      logic       ctrlReadyN;
      logic       rxIrqN;
      logic       txIrqN;
      logic [5:0] sadrHi;
      logic [9:0] sadrLo;
      logic [2:0] ioStraps;
      logic [2:0] romStraps;
      logic [1:0] mode;
   } hbd_pins_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_HOLD} hbd_state_t;

endpackage

// ==== common/hbd_sync_if.sv ====
// Carrier between the adapter top and its input synchroniser bank.
`timescale 1ns/1ps
interface hbd_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport filter (input raw, output clean);
   modport user   (output raw, input clean);
endinterface

// ==== verilog/hbd_input_sync.sv ====
// Three-stage synchroniser bank; a bit changes once stages two and three agree.
`timescale 1ns/1ps
module hbd_input_sync #(
   parameter int W = 8
) (
   input wire logic   clock,
   input wire logic   resetn,
   hbd_sync_if.filter pins
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] clean;
   } hbd_sync_state_t;

   hbd_sync_state_t q;
   hbd_sync_state_t next_q;

   // ----------------------------------------------------------------
   // Stage one feeds stage two only; filtering looks at two and three.
   // ----------------------------------------------------------------
   always_comb begin
      next_q       = q;
      next_q.s1    = pins.raw;
      next_q.s2    = q.s1;
      next_q.s3    = q.s2;
      next_q.clean = (q.s3 & ~(q.s2 ^ q.s3)) | (q.clean & (q.s2 ^ q.s3));
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         // The strobe and interrupt pins idle high, so reset loads ones and no false strobe or interrupt follows release.
         q <= '1;
      end else begin
         q <= next_q;
      end
   end

   assign pins.clean = q.clean;

endmodule

// ==== dv/hbd_host_model.sv ====
// Host expansion bus model that runs I/O and memory cycles.
`timescale 1ns/1ps
module hbd_host_model (
   input  wire logic       clock,
   output logic      [5:0] addrHigh,
   output logic      [9:0] addrLow,
   output logic            aen,
   output logic            dmaAckN,
   output logic            iorN,
   output logic            iowN,
   output logic            memrN,
   output logic            sysClk
);
   initial begin
      {addrHigh, addrLow} = 16'h0000;
      {aen, dmaAckN, iorN, iowN, memrN, sysClk} = 6'b11_1110;
   end
   // The bus clock runs free, unrelated in phase to the block clock.
   always #67 sysClk = ~sysClk;
   task automatic go(input logic [1:0] kind, input logic [15:0] a, input logic aenV, input logic dmaV);
      @(posedge clock);
      {addrHigh, addrLow} <= a;
      aen <= aenV;
      dmaAckN <= dmaV;
      @(posedge clock);
      iorN  <= (kind != 2'h0);
      iowN  <= (kind != 2'h1);
      memrN <= (kind != 2'h2);
   endtask
   task automatic done();
      @(posedge clock);
      {iorN, iowN, memrN} <= 3'b111;
      // A released address is not held, so show its inverse rather than the old value.
      {addrHigh, addrLow} <= ~{addrHigh, addrLow};
      {aen, dmaAckN} <= 2'b11;
      repeat (6) @(posedge clock);
   endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the host bus adapter decode block.
`timescale 1ns/1ps
module tb_top;
   // ----------------------------------------------------------------
   // Signals.
   // ----------------------------------------------------------------
   logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, er, aen, dma, iorN, iowN, memrN, sysClk;
   logic [5:0]  hiA;
   logic [9:0]  loA, base;
   logic        chRst = 1'b0, readyN = 1'b1, rxN = 1'b1, txN = 1'b1;
   logic [2:0]  ioS = 3'h0, romS = 3'h0;
   logic [1:0]  mode = 2'h0, rdyOut, rdyOe;
   logic        cycOut, cycOe, irq, data_regs_select_n, lSel, rSel, idSel, rdN, wrN, aRst;
   logic [3:0]  lla, r;
   logic [10:0] obs;
   int          n_fail = 0, checked = 0, seed = 24511, cycles = 0;
   assign obs = {cycOe, |rdyOe, &rdyOe, irq, aRst, wrN, rdN, idSel, rSel, lSel, data_regs_select_n};
   always #25 clock = ~clock;
   hbd_host_model host (.clock(clock), .addrHigh(hiA), .addrLow(loA), .aen(aen), .dmaAckN(dma), .iorN(iorN),
      .iowN(iowN), .memrN(memrN), .sysClk(sysClk));
   hbd_host_bus_adapter i_hbd_host_bus_adapter (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hostAddrHigh(hiA), .hostAddrLow(loA), .addrEnable(aen), .dmaAckN(dma), .ioReadN(iorN), .ioWriteN(iowN),
      .memReadN(memrN), .hostChannelReset(chRst), .hostSysClock(sysClk), .ioBaseStraps(ioS),
      .bootRomBaseStraps(romS), .modeStraps(mode), .hostChannelReadyOutsIn(~rdyOe),
      .hostChannelReadyOutsOut(rdyOut), .hostChannelReadyOutsOe(rdyOe), .cycleShortenOrWideNIn(~cycOe),
      .cycleShortenOrWideNOut(cycOut), .cycleShortenOrWideNOe(cycOe), .hostIrq(irq), .ctrlReadyN(readyN),
      .ctrlRxIrqN(rxN), .ctrlTxOrAnyIrqN(txN), .latchedLowAddr(lla), .dataRegsSelectN(data_regs_select_n),
      .linkRegsOrCtrlSelectN(lSel), .bootRomSelectN(rSel), .nodeIdRomSelectN(idSel), .ctrlReadN(rdN),
      .ctrlWriteN(wrN), .adapterReset(aRst));
   // ----------------------------------------------------------------
   // Tasks.
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (e !== g) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   // Polls one observed output until it takes the wanted level, with a bound.
   task automatic waitv(input int w, input logic v, input string nm);
      int k;
      k = 0;
      while (obs[w] !== v && k < 40) begin
         @(posedge clock);
         #1;
         k++;
      end
      check(nm, 32'(v), 32'(obs[w]));
   endtask
   task automatic quiet(input int w, input string nm);
      repeat (8) @(posedge clock);
      check(nm, 32'h0000_0001, 32'(obs[w]));
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge clock);
         k++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   // ----------------------------------------------------------------
   // Sequence: first mode with a narrow bus, then single select with a wide bus.
   // ----------------------------------------------------------------
   initial begin
      for (int m = 0; m < 2; m++) begin
         ioS <= 3'($random(seed));
         romS <= 3'($unsigned($random(seed)) % 7);
         mode <= (m == 1) ? 2'h3 : 2'h0;
         resetn <= 1'b0;
         repeat (6) @(posedge clock);
         resetn <= 1'b1;
         repeat (10) @(posedge clock);
         apb(12'h000, 1'b0, 32'h0000_0000);
         check("decode enable", 32'h0000_0001, {31'h0, rd[0]});
         apb(12'h00C, 1'b0, 32'h0000_0000);
         check("unmapped error", 32'h0000_0001, {31'h0, er});
         base = 10'h200 + {2'h0, ioS, 5'h00};
         r = 4'($random(seed));
         host.go(2'h0, {6'h0, base + {7'h0, r[2:0]}}, 1'b0, 1'b1);
         waitv(m, 1'b0, "controller select");
         waitv(4, 1'b0, "read strobe");
         check("latched address", {29'h0, r[2:0]}, {28'h0, lla});
         waitv(10, 1'b1, "cycle pin enable");
         waitv(8, 1'b1, "ready held");
         check("pin drive", 32'h0000_0000, {29'h0, cycOut, rdyOut});
         readyN <= 1'b0;
         waitv(9, 1'b0, "ready released");
         host.done();
         readyN <= 1'b1;
         waitv(4, 1'b1, "read strobe end");
         host.go(2'h1, {6'h0, base + {6'h0, 1'b1, r[2:0]}}, 1'b0, 1'b1);
         waitv(1, 1'b0, "link select");
         waitv(5, 1'b0, "write strobe");
         host.done();
         apb(12'h008, 1'b0, 32'h0000_0000);
         check("access count", 32'h0000_0002, rd);
         host.go(2'h0, {6'h0, base}, 1'b1, 1'b1);
         quiet(m, "select with address enable high");
         host.done();
         host.go(2'h0, {6'h0, base}, 1'b0, 1'b0);
         quiet(m, "select during dma acknowledge");
         host.done();
         apb(12'h000, 1'b1, 32'h0000_0000);
         host.go(2'h0, {6'h0, base}, 1'b0, 1'b1);
         quiet(m, "select with decode disabled");
         host.done();
         apb(12'h000, 1'b1, 32'h0000_0001);
         host.go(2'h0, {6'h0, base + {5'h02, r[2:0]}}, 1'b0, 1'b1);
         waitv(3, 1'b0, "id rom select");
         host.done();
         host.go(2'h2, {6'h30 + {3'h0, romS}, 10'h000}, 1'b1, 1'b1);
         waitv(2, 1'b0, "boot rom select");
         host.done();
         host.go(2'h2, {6'h2F, 10'h000}, 1'b1, 1'b1);
         quiet(2, "boot rom outside window");
         host.done();
         host.go(2'h1, {6'h0, base + {5'h03, r[2:0]}}, 1'b0, 1'b1);
         waitv(6, 1'b1, "write reset");
         host.done();
         waitv(6, 1'b0, "write reset end");
         chRst <= 1'b1;
         waitv(6, 1'b1, "channel reset");
         chRst <= 1'b0;
         waitv(6, 1'b0, "channel reset end");
         rxN <= 1'b0;
         waitv(7, 1'b1, "rx irq");
         rxN <= 1'b1;
         waitv(7, 1'b0, "rx irq end");
         txN <= 1'b0;
         waitv(7, 1'b1, "tx irq");
         txN <= 1'b1;
         waitv(7, 1'b0, "tx irq end");
      end
      give_verdict();
   end
endmodule
